// ===== core/clock_block.sv
`include "io_port_map.svh"
`default_nettype none

module clock_block
  import io_port_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic ref_tick,
  input wire logic src_rise,
  input wire clkblk_cfg_t cfg,
  output logic tick
);

  typedef struct packed {
    logic [`DIV_W-1:0] cnt;
  } blk_state_t;

  blk_state_t st_q;
  blk_state_t st_d;
  logic src_ev;

  // source: reference or an edge of the 1-bit port pin [R17]
  assign src_ev = cfg.use_pin ? src_rise : ref_tick;
  // divide by divide+1; >= keeps a lowered divisor from a long wrap [R18]
  assign tick = src_ev && (st_q.cnt >= cfg.divide);

  always_comb begin
    st_d = st_q;
    if (src_ev) begin
      st_d.cnt = tick ? '0 : st_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : clock_block

`default_nettype wire

// ===== core/io_port_map.svh
`ifndef IO_PORT_MAP_SVH
`define IO_PORT_MAP_SVH

// port set and pin field
`define NUM_PORTS 5
`define NUM_CLKBLK 6
`define NUM_PINS 32
`define XFER_W 32
`define CNT_W 16
`define SLOT_W 6
`define DIV_W 8
`define ATTACH_W 3

// port widths and serdes slots per transfer word, narrowest first
`define PORT_WIDTHS '{1, 4, 8, 16, 32}
`define PORT_SLOTS '{6'h20, 6'h08, 6'h04, 6'h02, 6'h01}

// the 1-bit port whose pin can clock a clock block
`define CLKSRC_PIN 0

// pins taken over by the inter-chip link when it is enabled
`define LINK_PIN_MASK 32'h000000F0

// reset attachment of every port: clock block 0
`define ATTACH_RESET 3'h0

// timing: system clock and tile reference clock
`define CLK_FREQ_MHZ 200
`define REF_FREQ_MHZ 100
`define REF_DIV_CYCLES (`CLK_FREQ_MHZ / `REF_FREQ_MHZ)

`endif

// ===== core/io_port_pkg.sv
`include "io_port_map.svh"
`default_nettype none

package io_port_pkg;

  typedef enum logic [1:0] {
    COND_NONE = 2'b00,
    COND_EQ = 2'b01,
    COND_NEQ = 2'b10
  } cond_mode_t;

  // per-port configuration, held by software outside
  typedef struct packed {
    logic enable;
    logic dir_out;
    logic open_drain;
    logic [`ATTACH_W-1:0] clk_sel;
    cond_mode_t cond;
    logic [`XFER_W-1:0] cond_value;
    logic strobe_in_en;
    logic strobe_out_en;
  } port_cfg_t;

  // one processor access to a port
  typedef struct packed {
    logic wr;
    logic rd;
    logic timed;
    logic [`CNT_W-1:0] when;
    logic [`XFER_W-1:0] data;
  } port_req_t;

  typedef struct packed {
    logic [`XFER_W-1:0] data;
    logic [`CNT_W-1:0] count;
    logic [`CNT_W-1:0] stamp;
    logic tx_free;
    logic rx_valid;
  } port_rsp_t;

  typedef struct packed {
    logic use_pin;
    logic [`DIV_W-1:0] divide;
  } clkblk_cfg_t;

  typedef struct packed {
    logic [`ATTACH_W-1:0] attach;
    logic [`CNT_W-1:0] count;
    logic [`CNT_W-1:0] stamp;
    logic [`XFER_W-1:0] xfer;
    logic xfer_full;
    logic [`XFER_W-1:0] shift;
    logic [`SLOT_W-1:0] slots;
    logic timed;
    logic [`CNT_W-1:0] when;
    logic [`XFER_W-1:0] pin_out;
    logic strobe;
    logic event_pulse;
  } port_state_t;

  typedef struct packed {
    port_state_t [`NUM_PORTS-1:0] ports;
    logic [1:0] ref_cnt;
    logic ref_tick;
    logic src_prev;
  } top_state_t;

endpackage : io_port_pkg

`default_nettype wire

// ===== core/io_port_tile.sv
// Summary of operation
// R1: ports of 1, 4, 8, 16 and 32 pins, each on that many pins.
// R2: every pin of a port shares one direction, in or out.
// R3: ports drive pins or sample them, optionally waiting for a pin condition.
// R4: each processor access to a port completes in one cycle.
// R5: open-drain output pulls low for zero and floats for one.
// R6: open-drain is chosen per port, not per pin.
// R7: data passes through a serdes stage plus a transfer register.
// R8: each port has a 16-bit counter that schedules transfers.
// R9: counter readable anytime; transfers may wait for a chosen count.
// R10: the counter is captured as a timestamp on each transfer.
// R11: an enabled link disables port functions on its shared pins; the code cuts only the port drive there, input ports still sample them.
// R12: an enabled port overrules wider ports on shared pins.
// R13: non-shared pins of the wider port stay usable.
// R14: a port always works at its full width.
// R15: six clock blocks; block 0 is the 100 MHz reference.
// R16: other blocks run at other rates and pace their ports.
// R17: a clock block may take a 1-bit port pin as source.
// R18: a clock block may divide its pin source.
// R19: ports accept an input strobe qualifying incoming data.
// R20: output ports can drive a strobe marking valid data.
// R21: after reset every port is attached to clock block 0.
// R22: pin events go straight to the scheduler, no interrupt.
// R23: port counter steps once per clock block tick and wraps.
`include "io_port_map.svh"
`default_nettype none

module io_port_tile
  import io_port_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [`NUM_PINS-1:0] PIN_I,
  output logic [`NUM_PINS-1:0] PIN_O,
  output logic [`NUM_PINS-1:0] PIN_OE,
  input wire logic [`NUM_PORTS-1:0] STROBE_IN,
  output logic [`NUM_PORTS-1:0] STROBE_OUT_QUALIFIER,
  input wire logic LINK_EN,
  input wire port_cfg_t [`NUM_PORTS-1:0] PORT_CFG,
  input wire clkblk_cfg_t [`NUM_CLKBLK-1:1] CLKBLK_CFG,
  input wire port_req_t [`NUM_PORTS-1:0] PORT_REQ,
  output port_rsp_t [`NUM_PORTS-1:0] PORT_RSP,
  output logic [`NUM_PORTS-1:0] PORT_EVENT,
  output logic [`NUM_CLKBLK-1:0] CLKBLK_TICK
);

  localparam int PORT_W [`NUM_PORTS] = `PORT_WIDTHS;
  localparam logic [`SLOT_W-1:0] PORT_N [`NUM_PORTS] = `PORT_SLOTS;
  localparam logic [`NUM_PINS-1:0] LINK_MASK = `LINK_PIN_MASK;
  localparam logic [1:0] REF_LAST = 2'(`REF_DIV_CYCLES - 1);

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  top_state_t st_q;
  top_state_t st_d;
  port_state_t port_nx [`NUM_PORTS];
  logic [`NUM_PINS-1:0] pin_s;
  logic [`NUM_PORTS-1:0] strobe_s;
  logic [`NUM_CLKBLK-1:0] blk_tick;
  logic src_rise;

  // pins and strobes come from outside: two flops before use
  pin_sync #(.W(`NUM_PINS + `NUM_PORTS)) u_sync (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .din({STROBE_IN, PIN_I}),
    .dout({strobe_s, pin_s})
  );

  // rising edge of the 1-bit port pin, a clock source for blocks [R17]
  assign src_rise = pin_s[`CLKSRC_PIN] && !st_q.src_prev;

  // six clock blocks; block 0 is fixed to the reference [R15] [R16]
  genvar b;
  generate
    for (b = 0; b < `NUM_CLKBLK; b++) begin : g_blk
      clkblk_cfg_t blk_cfg;
      if (b == 0) begin : g_ref
        assign blk_cfg = '0;
      end else begin : g_prog
        assign blk_cfg = CLKBLK_CFG[b];
      end
      clock_block u_blk (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .ref_tick(st_q.ref_tick),
        .src_rise(src_rise),
        .cfg(blk_cfg),
        .tick(blk_tick[b])
      );
    end
  endgenerate

  assign CLKBLK_TICK = blk_tick;

  // per-port serdes, transfer register, counter and timing
  genvar i;
  generate
    for (i = 0; i < `NUM_PORTS; i++) begin : g_port
      localparam int W = PORT_W[i];
      localparam logic [`SLOT_W-1:0] N = PORT_N[i];
      localparam logic [`XFER_W-1:0] MASK = '1 >> (`XFER_W - W);
      port_state_t cur;
      port_cfg_t cfg;
      port_req_t req;
      logic tick;
      logic time_ok;
      logic have;
      logic cond_ok;
      logic sample_ok;
      logic load;
      logic done;
      logic [`XFER_W-1:0] src;
      logic [`XFER_W-1:0] in_word;

      assign cur = st_q.ports[i];
      assign cfg = PORT_CFG[i];
      assign req = PORT_REQ[i];
      // attach codes 6 and 7 name no block and stop the port
      assign tick = (cur.attach < `ATTACH_W'(`NUM_CLKBLK)) ?
                    blk_tick[cur.attach] : 1'b0; // [R16]
      assign time_ok = !cur.timed || (cur.count == cur.when); // [R9]
      assign have = (cur.slots != '0) || (cur.xfer_full && time_ok);
      assign src = (cur.slots == '0) ? cur.xfer : cur.shift;
      // the pin condition gates only the first sample of a word
      always_comb begin
        unique case (cfg.cond)
          COND_EQ: cond_ok = (pin_s & MASK) == (cfg.cond_value & MASK);
          COND_NEQ: cond_ok = (pin_s & MASK) != (cfg.cond_value & MASK);
          default: cond_ok = 1'b1;
        endcase
      end
      assign sample_ok = (!cfg.strobe_in_en || strobe_s[i]) && // [R19]
                         ((cur.slots != '0) || (cond_ok && time_ok)); // [R3]
      assign in_word = (cur.shift >> W) | (pin_s << (`XFER_W - W)); // [R14]

      always_comb begin
        port_nx[i] = cur;
        load = 1'b0;
        done = 1'b0;
        port_nx[i].event_pulse = 1'b0;
        if (tick) begin
          port_nx[i].count = cur.count + 16'h0001; // [R8] [R23]
        end
        // clock attachment changes only while the port is off [R21]
        if (!cfg.enable) begin
          port_nx[i].attach = cfg.clk_sel;
          port_nx[i].strobe = 1'b0;
        end else if (cfg.dir_out) begin
          // whole port drives: one direction for all its pins [R2]
          if (tick) begin
            port_nx[i].strobe = have && cfg.strobe_out_en; // [R20]
            if (have) begin
              port_nx[i].pin_out = src & MASK; // [R7]
              port_nx[i].shift = src >> W;
              port_nx[i].slots = ((cur.slots == '0) ? N : cur.slots) -
                                 6'h01;
              if (cur.slots == '0) begin
                load = 1'b1;
                port_nx[i].xfer_full = 1'b0;
                port_nx[i].timed = 1'b0;
                port_nx[i].stamp = cur.count; // [R10]
                port_nx[i].event_pulse = 1'b1; // [R22]
              end
            end
          end
          // a write into a full transfer register is dropped
          if (req.wr && !cur.xfer_full) begin
            port_nx[i].xfer = req.data; // [R4]
            port_nx[i].xfer_full = 1'b1;
            port_nx[i].timed = req.timed;
            port_nx[i].when = req.when;
          end
        end else begin
          port_nx[i].strobe = 1'b0;
          if (tick && sample_ok) begin
            port_nx[i].shift = in_word; // [R7]
            if (cur.slots == N - 6'h01) begin
              done = 1'b1;
              port_nx[i].slots = '0;
              port_nx[i].xfer = in_word; // overrun keeps newest word
              port_nx[i].xfer_full = 1'b1;
              port_nx[i].timed = 1'b0;
              port_nx[i].stamp = cur.count; // [R10]
              port_nx[i].event_pulse = 1'b1; // [R22]
            end else begin
              port_nx[i].slots = cur.slots + 6'h01;
            end
          end
          // a write to an input port arms a timed input [R9]
          if (req.wr) begin
            port_nx[i].timed = req.timed;
            port_nx[i].when = req.when;
          end
          // an arriving word beats a read in the same cycle
          if (req.rd && !done) begin
            port_nx[i].xfer_full = 1'b0; // [R4]
          end
        end
      end

      // registered answers, readable in the same cycle [R4] [R9]
      assign PORT_RSP[i].data = cur.xfer;
      assign PORT_RSP[i].count = cur.count;
      assign PORT_RSP[i].stamp = cur.stamp;
      assign PORT_RSP[i].tx_free = cfg.dir_out && !cur.xfer_full;
      assign PORT_RSP[i].rx_valid = !cfg.dir_out && cur.xfer_full;
      assign STROBE_OUT_QUALIFIER[i] = cur.strobe;
      assign PORT_EVENT[i] = cur.event_pulse;

      a_count_wrap: assert property ( // [R23]
        tick && cur.count == 16'hFFFF |=> st_q.ports[i].count == 16'h0000)
        else $error("port counter did not wrap to zero");
      a_timed_load: assert property ( // [R9]
        load |-> !cur.timed || cur.count == cur.when)
        else $error("timed output left before its count");
      a_stamp_taken: assert property ( // [R10]
        load || done |=> st_q.ports[i].stamp == $past(cur.count))
        else $error("timestamp not captured on transfer");
      a_strobe_out: assert property ( // [R20]
        tick && have && cfg.enable && cfg.dir_out && cfg.strobe_out_en
        |=> STROBE_OUT_QUALIFIER[i])
        else $error("output strobe missing with data");
      a_word_event: assert property ( // [R22]
        done |=> PORT_EVENT[i] && PORT_RSP[i].rx_valid ##1 !PORT_EVENT[i])
        else $error("input word gave no single event");
      a_write_taken: assert property ( // [R4]
        req.wr && cfg.enable && cfg.dir_out && !cur.xfer_full
        |=> !PORT_RSP[i].tx_free)
        else $error("port write not taken in one cycle");
      a_attach_hold: assert property ( // [R21]
        cfg.enable && $past(cfg.enable) |-> $stable(cur.attach))
        else $error("clock attachment changed on a live port");
    end
  endgenerate

  // pin ownership: narrowest enabled port wins, link overrides all
  generate
    for (b = 0; b < `NUM_PINS; b++) begin : g_pin
      logic found;
      logic od_sel;
      logic drv_bit;
      always_comb begin
        found = 1'b0;
        od_sel = 1'b0;
        drv_bit = 1'b0;
        PIN_O[b] = 1'b0;
        PIN_OE[b] = 1'b0;
        for (int k = 0; k < `NUM_PORTS; k++) begin
          // ports beyond their width leave this pin to wider ones [R13]
          if (!found && PORT_CFG[k].enable && b < PORT_W[k]) begin // [R1]
            found = 1'b1; // [R12]
            if (PORT_CFG[k].dir_out) begin
              drv_bit = st_q.ports[k].pin_out[b];
              od_sel = PORT_CFG[k].open_drain; // [R6]
              PIN_O[b] = od_sel ? 1'b0 : drv_bit; // [R5]
              PIN_OE[b] = od_sel ? !drv_bit : 1'b1;
            end
          end
        end
        if (LINK_EN && LINK_MASK[b]) begin
          od_sel = 1'b0;
          PIN_O[b] = 1'b0; // [R11]
          PIN_OE[b] = 1'b0;
        end
      end

      a_link_pins_off: assert property ( // [R11]
        LINK_EN && LINK_MASK[b] |-> !PIN_OE[b])
        else $error("link pin still driven by a port");
      a_od_float: assert property ( // [R5]
        od_sel && drv_bit |-> !PIN_OE[b] && !PIN_O[b])
        else $error("open-drain one was not left floating");
    end
  endgenerate

  // reference tick and pin-edge history
  always_comb begin
    st_d = st_q;
    for (int k = 0; k < `NUM_PORTS; k++) begin
      st_d.ports[k] = port_nx[k];
    end
    st_d.src_prev = pin_s[`CLKSRC_PIN];
    st_d.ref_cnt = (st_q.ref_cnt == REF_LAST) ? 2'h0 : st_q.ref_cnt + 2'h1;
    st_d.ref_tick = (st_q.ref_cnt == REF_LAST); // [R15]
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '0; // attach 0 = clock block 0 [R21]
    end else begin
      st_q <= st_d;
    end
  end

  sequence ref_pair_s;
    st_q.ref_tick ##1 !st_q.ref_tick ##1 st_q.ref_tick;
  endsequence

  a_ref_rate: assert property ( // [R15]
    st_q.ref_tick |-> ref_pair_s)
    else $error("reference tick not at half the system clock");
  a_narrow_wins: assert property ( // [R12]
    PORT_CFG[0].enable && PORT_CFG[0].dir_out && !PORT_CFG[0].open_drain &&
    !(LINK_EN && LINK_MASK[0])
    |-> PIN_OE[0] && PIN_O[0] == st_q.ports[0].pin_out[0])
    else $error("narrow port lost its shared pin");

endmodule : io_port_tile

`default_nettype wire

// ===== core/pin_sync.sv
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  // the first stage feeds only the second stage
  always_comb begin
    st_d.meta = din;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.stable;

endmodule : pin_sync

`default_nettype wire

// ===== verif/pin_partner.sv
`default_nettype none

// far side of the pins: drives a word and its strobe, pulled down when idle
module pin_partner (
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  input wire logic drive,
  input wire logic [31:0] value,
  output logic [31:0] pin_i,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // device output wins; a floating line reads low through its pull-down
  always_comb begin
    for (int b = 0; b < 32; b++) begin
      if (pin_oe[b]) begin
        pin_i[b] = pin_o[b];
      end else begin
        pin_i[b] = drive & value[b];
      end
    end
  end

  // strobe travels alongside the data it qualifies
  assign strobe = drive;
endmodule : pin_partner

`default_nettype wire

// ===== verif/test_timed_serdes_io_port_clocking.sv
`include "io_port_map.svh"
`default_nettype none

`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("unexpected %s exp %h got %h", nm, e, g); \
  end \
end

module test_timed_serdes_io_port_clocking
  import io_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic rst_n;
  logic link_en;
  logic drive;
  logic strobe;
  logic [31:0] value;
  logic [31:0] pin_i;
  logic [31:0] pin_o;
  logic [31:0] pin_oe;
  logic [`NUM_PORTS-1:0] str_out;
  logic [`NUM_PORTS-1:0] event_p;
  logic [`NUM_CLKBLK-1:0] ticks;
  port_cfg_t [`NUM_PORTS-1:0] cfg;
  clkblk_cfg_t [`NUM_CLKBLK-1:1] cb;
  port_req_t [`NUM_PORTS-1:0] req;
  port_rsp_t [`NUM_PORTS-1:0] rsp;
  int error_cnt;
  int n_tests;
  logic [31:0] v;
  logic [31:0] d;
  logic [15:0] c0;
  logic [15:0] w;
  logic [7:0] nt;
  logic [7:0] exp_q[$];

  io_port_tile DUT (
    .CLOCK(clock),
    .RST_N(rst_n),
    .PIN_I(pin_i),
    .PIN_O(pin_o),
    .PIN_OE(pin_oe),
    .STROBE_IN({`NUM_PORTS{strobe}}),
    .STROBE_OUT_QUALIFIER(str_out),
    .LINK_EN(link_en),
    .PORT_CFG(cfg),
    .CLKBLK_CFG(cb),
    .PORT_REQ(req),
    .PORT_RSP(rsp),
    .PORT_EVENT(event_p),
    .CLKBLK_TICK(ticks)
  );

  pin_partner far_side (
    .pin_o(pin_o),
    .pin_oe(pin_oe),
    .drive(drive),
    .value(value),
    .pin_i(pin_i),
    .strobe(strobe)
  );

  // 200 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // bounded wait for a port event; a miss ends the run
  task automatic wait_ev(input int p);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      #1;
      if (event_p[p] === 1'b1) begin
        break;
      end
    end
    if (i == 200) begin
      error_cnt++;
      summarize();
    end
  endtask : wait_ev

  // one-cycle write pulse on port 2, then the model queues its 4 chunks
  task automatic send(input logic [31:0] dw, input logic t,
                      input logic [15:0] wh);
    `CHK("tx_free", 1'b1, rsp[2].tx_free)
    @(posedge clock);
    req[2].wr <= 1'b1;
    req[2].data <= dw;
    req[2].timed <= t;
    req[2].when <= wh;
    @(posedge clock);
    req[2].wr <= 1'b0;
    #1;
    `CHK("tx_busy", 1'b0, rsp[2].tx_free)
    for (int k = 0; k < 4; k++) begin
      exp_q.push_back(dw[8*k +: 8]);
    end
  endtask : send

  // pins 7..0 against the next queued chunk, lsb chunk first
  task automatic chunk(input logic od);
    logic [7:0] c;
    c = exp_q.pop_front();
    `CHK("pin_o", od ? 8'h00 : c, pin_o[7:0])
    `CHK("pin_oe", od ? ~c : 8'hFF, pin_oe[7:0])
  endtask : chunk

  initial begin
    rst_n = 1'b0;
    link_en = 1'b0;
    drive = 1'b0;
    value = 32'h0;
    cfg = '0;
    cb = '0;
    req = '0;
    error_cnt = 0;
    n_tests = 0;
    void'($urandom(7));
    // bit 8 set keeps the wanted word apart from idle and pin-clock values
    v = $urandom() | 32'h100;
    cfg[4].enable = 1'b1;
    cfg[4].strobe_in_en = 1'b1;
    cfg[4].cond = COND_EQ;
    cfg[4].cond_value = v;
    cfg[3].clk_sel = 3'h1;
    cb[1].use_pin = 1'b1;
    cb[1].divide = 8'h01;
    repeat (3) @(posedge clock);
    #1;
    `CHK("oe_rst", 32'h0, pin_oe)
    `CHK("cnt_rst", 16'h0, rsp[4].count)
    @(posedge clock);
    rst_n <= 1'b1;
    // reference rate seen through a block-0 port counter
    repeat (4) @(posedge clock);
    #1;
    c0 = rsp[4].count;
    // block 0 and an unprogrammed block 5 both tick at the reference rate
    nt = 8'h00;
    repeat (20) begin
      @(posedge clock);
      #1;
      nt += ticks[0] + ticks[5];
    end
    w = rsp[4].count - c0;
    `CHK("ref_rate", 16'(20 / `REF_DIV_CYCLES), w)
    `CHK("blk_tick", 8'(2 * 20 / `REF_DIV_CYCLES), nt)
    // strobed input that waits for the pins to match
    @(posedge clock);
    drive <= 1'b1;
    value <= v;
    wait_ev(4);
    `CHK("rx_word", v, rsp[4].data)
    `CHK("rx_valid", 1'b1, rsp[4].rx_valid)
    @(posedge clock);
    value <= 32'h0;
    // 8 pin-0 clocks divided by 2 pace port 3
    repeat (4) @(posedge clock);
    #1;
    c0 = rsp[3].count;
    repeat (8) begin
      repeat (4) @(posedge clock);
      value <= 32'h1;
      repeat (4) @(posedge clock);
      value <= 32'h0;
    end
    repeat (8) @(posedge clock);
    #1;
    `CHK("pin_clk", 16'h4, 16'(rsp[3].count - c0))
    // port 2 narrower output over port 3 and the 32-bit input
    @(posedge clock);
    drive <= 1'b0;
    // one-cycle read of the waiting input word
    req[4].rd <= 1'b1;
    cfg[2].enable <= 1'b1;
    cfg[2].dir_out <= 1'b1;
    cfg[2].strobe_out_en <= 1'b1;
    cfg[3].enable <= 1'b1;
    cfg[3].dir_out <= 1'b1;
    @(posedge clock);
    req[4].rd <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("own_oe", 32'h0000FFFF, pin_oe)
    `CHK("rx_read", 1'b0, rsp[4].rx_valid)
    // modes: plain, timed, open drain
    for (int m = 0; m < 3; m++) begin
      d = $urandom();
      @(posedge clock);
      cfg[2].open_drain <= (m == 2);
      #1;
      w = 16'(rsp[2].count + 16'd20);
      send(d, m == 1, w);
      wait_ev(2);
      if (m == 1) begin
        `CHK("stamp", w, rsp[2].stamp)
      end
      `CHK("strobe", 1'b1, str_out[2])
      chunk(m == 2);
      for (int k = 1; k < 4; k++) begin
        repeat (2) @(posedge clock);
        #1;
        chunk(m == 2);
      end
      `CHK("wide_oe", 8'hFF, pin_oe[15:8])
    end
    // link takes pins 7..4 away from port 2
    @(posedge clock);
    cfg[2].open_drain <= 1'b0;
    // the 1-bit output port takes pin 0 back from port 2
    cfg[0].enable <= 1'b1;
    cfg[0].dir_out <= 1'b1;
    link_en <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("link_oe", 16'hFF0F, pin_oe[15:0])
    `CHK("narrow_o", 1'b0, pin_o[0])
    summarize();
  end
endmodule : test_timed_serdes_io_port_clocking

`undef CHK
`default_nettype wire
